/* common/sbio_pkg.sv */
package sbio_pkg;

   // ==========================================================
   // sizes and register indices (byte address = index * 4)
   localparam int SBIO_PINS = 6;
   localparam logic [7:0] SBIO_IDX_DATA = 8'h05;
   localparam logic [7:0] SBIO_IDX_DIR = 8'h85;
   localparam logic [7:0] SBIO_IDX_ACFG = 8'h9f;

   // ==========================================================
   // reset values and field positions
   localparam logic [5:0] SBIO_DIR_RST = 6'h3f;
   localparam logic [5:0] SBIO_LATCH_POR = 6'h00;
   localparam logic SBIO_FMT_RST = 1'h0;
   localparam logic [3:0] SBIO_SEL_RST = 4'h0;
   localparam int SBIO_FMT_BIT = 7;
   localparam int SBIO_SEL_MSB = 3;
   localparam int SBIO_TMR_PIN = 4;
   localparam int SBIO_SS_PIN = 5;
   localparam logic [5:0] SBIO_TMR_MASK = 6'h10;
   localparam logic [5:0] SBIO_SS_MASK = 6'h20;

   // ==========================================================
   // analog masks per pin-select setting
   localparam logic [5:0] SBIO_AMASK_ALL = 6'h2f;
   localparam logic [5:0] SBIO_AMASK_LOW4 = 6'h0f;
   localparam logic [5:0] SBIO_AMASK_P013 = 6'h0b;
   localparam logic [5:0] SBIO_AMASK_P03 = 6'h09;
   localparam logic [5:0] SBIO_AMASK_P0 = 6'h01;
   localparam logic [5:0] SBIO_AMASK_NONE = 6'h00;

   // ==========================================================
   // bus answers
   localparam logic [1:0] SBIO_RESP_OKAY = 2'h0;
   localparam logic [1:0] SBIO_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SBIO_SEL_NONE, SBIO_SEL_DATA, SBIO_SEL_DIR, SBIO_SEL_ACFG} sbio_sel_t;

   typedef struct packed {
      logic ref_sel;
      logic [5:0] mask;
   } sbio_acfg_t;

   typedef struct packed {
      logic [5:0] latch;
      logic [5:0] dir;
      logic fmt;
      logic [3:0] sel;
   } sbio_regs_t;

   typedef struct packed {
      sbio_regs_t regs;
      logic aw_held;
      sbio_sel_t aw_sel;
      logic w_held;
      logic [7:0] w_data;
      logic w_strb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [5:0] pin_out;
      logic [5:0] pin_oe;
      logic [5:0] analog_en;
      logic ref_sel;
      logic tmr_clk;
      logic ss;
   } sbio_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } sbio_sync_t;

   // word address decode, shared by read and write paths
   function automatic sbio_sel_t sbio_decode(input logic [31:0] a);
      sbio_sel_t s;
      s = SBIO_SEL_NONE;
      if (a[31:10] != '0 || a[1:0] != '0) begin
         s = SBIO_SEL_NONE;
      end else if (a[9:2] == SBIO_IDX_DATA) begin
         s = SBIO_SEL_DATA;
      end else if (a[9:2] == SBIO_IDX_DIR) begin
         s = SBIO_SEL_DIR;
      end else if (a[9:2] == SBIO_IDX_ACFG) begin
         s = SBIO_SEL_ACFG;
      end
      return s;
   endfunction : sbio_decode

   // pin-select setting to analog mask and reference choice
   function automatic sbio_acfg_t sbio_analog(input logic [3:0] sel);
      sbio_acfg_t r;
      r.ref_sel = sel[0] | (sel[3] & ~sel[2]);
      case (sel)
         4'h4, 4'h5: r.mask = SBIO_AMASK_P013;
         4'h6, 4'h7: r.mask = SBIO_AMASK_NONE;
         4'hd: r.mask = SBIO_AMASK_LOW4;
         4'he: r.mask = SBIO_AMASK_P0;
         4'hf: r.mask = SBIO_AMASK_P03;
         default: r.mask = SBIO_AMASK_ALL;
      endcase
      return r;
   endfunction : sbio_analog

endpackage : sbio_pkg

/* design/sbio_pin_sync.sv */
`timescale 1ns/1ps
module sbio_pin_sync
   import sbio_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic d_i,
   output logic q_o
);

   sbio_sync_t st;
   sbio_sync_t next_st;

   // ==========================================================
   // three-stage chain; output follows once stages two and three agree
   always_comb begin
      next_st = st;
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3) begin
         next_st.q = st.s3;
      end
      if (reset_i) begin
         next_st = '0;
      end
   end

   // register the whole state; enable freezes it except during reset
   always_ff @(posedge clk_i) begin
      if (ce_i || reset_i) begin
         st <= next_st;
      end
   end

   assign q_o = st.q;

endmodule : sbio_pin_sync

/* design/sbio_port.sv */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// Operation
// - six-pin port, each pin with its own direction and latch bit
// - direction one makes the pin an input, driver released
// - direction zero drives the pin from its latch bit
// - data reads return pin levels; writes only load the latch
// - every data write is read-modify-write of the whole latch
// - pin four feeds the timer clock and is open-drain
// - other pins analog or digital per the pin-select field
// - power-on makes analog pins analog, digital reads give zero
// - direction bits still steer drivers of analog pins
// - pin five is serial slave select and an analog input
// - pin three is analog input or reference input by setting
// - upper two bits of data and direction read zero
// - other resets keep latch, set direction to all ones
// - enabled peripheral takes its pin from general use
module sbio_port
   import sbio_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic POR_I,
   input wire logic CE_I,
   input wire logic [5:0] PIN_I,
   output logic [5:0] PIN_O,
   output logic [5:0] PIN_OE_O,
   input wire logic SS_PERIPH_EN_I,
   output logic [5:0] ANALOG_EN_O,
   output logic REF_SEL_O,
   output logic RESULT_FMT_O,
   output logic TMR_CLK_O,
   output logic SS_O,
   input wire logic [31:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [31:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);

   sbio_state_t st;
   sbio_state_t next_st;
   logic [5:0] pin_sync;
   logic [5:0] digital_in;
   sbio_acfg_t acfg_now;
   sbio_acfg_t acfg_next;
   logic wr_go;
   sbio_sel_t rd_sel;
   logic any_reset;

   assign any_reset = RESET_I | POR_I;

   // ==========================================================
   // pin input synchronisers, one per pin
   for (genvar i = 0; i < SBIO_PINS; i++) begin : g_sync
      sbio_pin_sync u_sync (
         .clk_i(CLK_I),
         .reset_i(any_reset),
         .ce_i(CE_I),
         .d_i(PIN_I[i]),
         .q_o(pin_sync[i])
      );
   end

   // ==========================================================
   // digital view of the pins: analog pins read zero
   assign acfg_now = sbio_analog(st.regs.sel);
   assign digital_in = pin_sync & ~acfg_now.mask;

   // ==========================================================
   // next-state logic: bus slave, registers, pin drive
   always_comb begin
      next_st = st;
      wr_go = 1'b0;
      rd_sel = SBIO_SEL_NONE;
      acfg_next = '0;
      // write address and data are taken independently
      if (S_AXI_AWVALID_I && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_sel = sbio_decode(S_AXI_AWADDR_I);
      end
      if (S_AXI_WVALID_I && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = S_AXI_WDATA_I[7:0];
         next_st.w_strb0 = S_AXI_WSTRB_I[0];
      end
      // write proceeds once both halves are held
      wr_go = next_st.aw_held && next_st.w_held && !st.bvalid;
      if (wr_go) begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = SBIO_RESP_OKAY;
         if (next_st.aw_sel == SBIO_SEL_DATA) begin
            // pins sampled, byte lane merged, whole latch stored
            if (next_st.w_strb0) begin
               next_st.regs.latch = next_st.w_data[5:0];
            end else begin
               next_st.regs.latch = digital_in;
            end
         end else if (next_st.aw_sel == SBIO_SEL_DIR) begin
            if (next_st.w_strb0) begin
               next_st.regs.dir = next_st.w_data[5:0];
            end
         end else if (next_st.aw_sel == SBIO_SEL_ACFG) begin
            if (next_st.w_strb0) begin
               next_st.regs.fmt = next_st.w_data[SBIO_FMT_BIT];
               next_st.regs.sel = next_st.w_data[SBIO_SEL_MSB:0];
            end
         end else begin
            next_st.bresp = SBIO_RESP_SLVERR;
         end
      end else if (st.bvalid && S_AXI_BREADY_I) begin
         next_st.bvalid = 1'b0;
      end
      // read: one at a time, answer the cycle after the address
      if (S_AXI_ARVALID_I && st.arready) begin
         rd_sel = sbio_decode(S_AXI_ARADDR_I);
         next_st.rvalid = 1'b1;
         next_st.rresp = SBIO_RESP_OKAY;
         next_st.rdata = '0;
         case (rd_sel)
            SBIO_SEL_DATA: next_st.rdata[5:0] = digital_in;
            SBIO_SEL_DIR: next_st.rdata[5:0] = st.regs.dir;
            SBIO_SEL_ACFG: begin
               next_st.rdata[SBIO_FMT_BIT] = st.regs.fmt;
               next_st.rdata[SBIO_SEL_MSB:0] = st.regs.sel;
            end
            default: next_st.rresp = SBIO_RESP_SLVERR;
         endcase
      end else if (st.rvalid && S_AXI_RREADY_I) begin
         next_st.rvalid = 1'b0;
      end
      // resets: power-on clears the latch; both set direction to all ones; other resets keep the latch
      if (POR_I) begin
         next_st = '0;
         next_st.regs.latch = SBIO_LATCH_POR;
         next_st.regs.dir = SBIO_DIR_RST;
         next_st.regs.fmt = SBIO_FMT_RST;
         next_st.regs.sel = SBIO_SEL_RST;
      end else if (RESET_I) begin
         next_st = '0;
         next_st.regs.latch = st.regs.latch;
         next_st.regs.dir = SBIO_DIR_RST;
         next_st.regs.fmt = SBIO_FMT_RST;
         next_st.regs.sel = SBIO_SEL_RST;
      end else begin
         next_st.awready = !next_st.aw_held && !next_st.bvalid;
         next_st.wready = !next_st.w_held && !next_st.bvalid;
         next_st.arready = !next_st.rvalid;
      end
      // pin drive: direction steers every driver, analog or not
      acfg_next = sbio_analog(next_st.regs.sel);
      next_st.pin_out = next_st.regs.latch & ~SBIO_TMR_MASK;
      next_st.pin_oe = ~next_st.regs.dir
         & ~(SBIO_TMR_MASK & next_st.regs.latch)
         & ~({SBIO_PINS{SS_PERIPH_EN_I}} & SBIO_SS_MASK);
      next_st.analog_en = acfg_next.mask;
      next_st.ref_sel = acfg_next.ref_sel;
      next_st.tmr_clk = pin_sync[SBIO_TMR_PIN];
      next_st.ss = digital_in[SBIO_SS_PIN];
      if (any_reset) begin
         next_st.tmr_clk = 1'b0;
         next_st.ss = 1'b0;
      end
   end

   // ==========================================================
   // state register; enable freezes everything except reset
   always_ff @(posedge CLK_I) begin
      if (CE_I || any_reset) begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   assign PIN_O = st.pin_out;
   assign PIN_OE_O = st.pin_oe;
   assign ANALOG_EN_O = st.analog_en;
   assign REF_SEL_O = st.ref_sel;
   assign RESULT_FMT_O = st.regs.fmt;
   assign TMR_CLK_O = st.tmr_clk;
   assign SS_O = st.ss;
   assign S_AXI_AWREADY_O = st.awready;
   assign S_AXI_WREADY_O = st.wready;
   assign S_AXI_BRESP_O = st.bresp;
   assign S_AXI_BVALID_O = st.bvalid;
   assign S_AXI_ARREADY_O = st.arready;
   assign S_AXI_RDATA_O = st.rdata;
   assign S_AXI_RRESP_O = st.rresp;
   assign S_AXI_RVALID_O = st.rvalid;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (any_reset);

   sequence s_ar_take(sbio_sel_t s);
      CE_I && S_AXI_ARVALID_I && S_AXI_ARREADY_O && sbio_decode(S_AXI_ARADDR_I) == s;
   endsequence

   sequence s_data_write;
      CE_I && wr_go && next_st.aw_sel == SBIO_SEL_DATA;
   endsequence

   // input pins never driven
   a_input_pin_hiz: assert property ((PIN_OE_O & st.regs.dir) == '0)
      else $error("pin driven while direction says input");

   // output pins zero to three follow the latch
   a_output_drive: assert property (
      PIN_OE_O[3:0] == ~st.regs.dir[3:0] && PIN_O[3:0] == st.regs.latch[3:0])
      else $error("output pin not driven from latch");

   // timer pin only pulls low
   a_open_drain: assert property (!PIN_O[SBIO_TMR_PIN]
      && PIN_OE_O[SBIO_TMR_PIN] == (!st.regs.dir[SBIO_TMR_PIN] && !st.regs.latch[SBIO_TMR_PIN]))
      else $error("timer pin not open drain");

   // data read returns pin levels
   a_read_pins: assert property (s_ar_take(SBIO_SEL_DATA) |=>
      S_AXI_RVALID_O && S_AXI_RDATA_O == 32'($past(digital_in)))
      else $error("data read does not return pins");

   // upper direction bits read zero
   a_upper_zero: assert property (s_ar_take(SBIO_SEL_DIR) |=>
      S_AXI_RDATA_O[31:6] == '0 && S_AXI_RDATA_O[5:0] == $past(st.regs.dir))
      else $error("direction read wrong");

   // configuration readback
   a_acfg_readback: assert property (s_ar_take(SBIO_SEL_ACFG) |=>
      S_AXI_RDATA_O == 32'({$past(st.regs.fmt), 3'h0, $past(st.regs.sel)}))
      else $error("configuration read wrong");

   // write stores merged pin sample into whole latch
   a_rmw_write: assert property (s_data_write |=> st.regs.latch ==
      ($past(next_st.w_strb0) ? $past(next_st.w_data[5:0]) : $past(digital_in)))
      else $error("data write not read-modify-write");

   // data read shows zero on every pin that was analog when the address was taken
   a_analog_zero: assert property (s_ar_take(SBIO_SEL_DATA) |=> (S_AXI_RDATA_O[5:0] & $past(ANALOG_EN_O)) == '0)
      else $error("analog pin reads nonzero");

   // power-on makes pins analog and drivers off, both one cycle later
   a_por_analog: assert property (disable iff (1'b0) POR_I |=>
      ANALOG_EN_O == SBIO_AMASK_ALL && PIN_OE_O == '0)
      else $error("power-on state wrong");

   // warm reset keeps latch and sets directions
   a_reset_keep: assert property (disable iff (POR_I) RESET_I |=>
      st.regs.dir == SBIO_DIR_RST && st.regs.latch == $past(st.regs.latch))
      else $error("reset state wrong");

   // slave select peripheral releases pin five
   a_ss_override: assert property (CE_I && SS_PERIPH_EN_I |=> !PIN_OE_O[SBIO_SS_PIN])
      else $error("pin five driven while peripheral owns it");

endmodule : sbio_port

/* bench/sbio_pins_model.sv */
`timescale 1ns/1ps
// ==========================================================
// board side of the six pins: a driven pin follows the block,
// a released pin follows the external source
module sbio_pins_model
   import sbio_pkg::*;
(
   input wire logic [5:0] pin_o_i,
   input wire logic [5:0] pin_oe_i,
   input wire logic [5:0] ext_val_i,
   output logic [5:0] pin_lvl_o
);
   // wire level from the block's enable: its output bit when driven, else the external source
   always_comb begin
      for (int i = 0; i < SBIO_PINS; i++) begin
         pin_lvl_o[i] = pin_oe_i[i] ? pin_o_i[i] : ext_val_i[i];
      end
      // the timer pin can only pull low, whatever the output bit says
      if (pin_oe_i[SBIO_TMR_PIN]) pin_lvl_o[SBIO_TMR_PIN] = 1'h0;
   end
endmodule : sbio_pins_model

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
   import sbio_pkg::*;
   // ==========================================================
   // bench signals
   logic CLK_I = 1'h0;
   logic RESET_I = 1'h1;
   logic POR_I = 1'h1;
   logic CE_I = 1'h1;
   logic SS_PERIPH_EN_I = 1'h0;
   logic [5:0] PIN_I, PIN_O, PIN_OE_O, ANALOG_EN_O;
   logic REF_SEL_O, RESULT_FMT_O, TMR_CLK_O, SS_O;
   logic [31:0] S_AXI_AWADDR_I = 32'h0, S_AXI_WDATA_I = 32'h0, S_AXI_ARADDR_I = 32'h0, S_AXI_RDATA_O;
   logic [3:0] S_AXI_WSTRB_I = 4'h0;
   logic S_AXI_AWVALID_I = 1'h0, S_AXI_WVALID_I = 1'h0, S_AXI_BREADY_I = 1'h0;
   logic S_AXI_ARVALID_I = 1'h0, S_AXI_RREADY_I = 1'h0;
   logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
   logic [5:0] ext_val = 6'h3f;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   localparam logic [31:0] ADR_DATA = 32'({SBIO_IDX_DATA, 2'h0});
   localparam logic [31:0] ADR_DIR = 32'({SBIO_IDX_DIR, 2'h0});
   localparam logic [31:0] ADR_CFG = 32'({SBIO_IDX_ACFG, 2'h0});
   localparam logic [1:0] OK = SBIO_RESP_OKAY;
   localparam logic [5:0] AMASK [16] = '{6'h2f, 6'h2f, 6'h2f, 6'h2f, 6'h0b, 6'h0b, 6'h00, 6'h00,
                                         6'h2f, 6'h2f, 6'h2f, 6'h2f, 6'h2f, 6'h0f, 6'h01, 6'h09};
   // reference choice per pin-select setting, bit k for setting k
   localparam logic [15:0] REFS = 16'hafaa;

   // clock
   always #2.5 CLK_I = ~CLK_I;

   // ==========================================================
   // design and board
   sbio_port sbio_port_i (.CLK_I, .RESET_I, .POR_I, .CE_I, .PIN_I, .PIN_O, .PIN_OE_O, .SS_PERIPH_EN_I,
      .ANALOG_EN_O, .REF_SEL_O, .RESULT_FMT_O, .TMR_CLK_O, .SS_O, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I,
      .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O,
      .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
      .S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I);
   sbio_pins_model sbio_pins_model_i (.pin_o_i(PIN_O), .pin_oe_i(PIN_OE_O), .ext_val_i(ext_val),
      .pin_lvl_o(PIN_I));

   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge CLK_I);
   endtask : tick

   // one write: address and data offered together, each dropped when taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      n = 0;
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= d;
      S_AXI_WSTRB_I <= s;
      S_AXI_AWVALID_I <= 1'h1;
      S_AXI_WVALID_I <= 1'h1;
      S_AXI_BREADY_I <= 1'h1;
      do begin
         @(posedge CLK_I);
         n++;
         if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'h0;
         if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'h0;
      end while (S_AXI_BVALID_O !== 1'h1 && n < 64);
      chk("bresp", {29'h0, 1'h1, er}, 32'({S_AXI_BVALID_O, S_AXI_BRESP_O}));
      S_AXI_BREADY_I <= 1'h0;
   endtask : wr

   // one read, data and response compared at the handshake edge
   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1'h1;
      S_AXI_RREADY_I <= 1'h1;
      do begin
         @(posedge CLK_I);
         n++;
         if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'h0;
      end while (S_AXI_RVALID_O !== 1'h1 && n < 64);
      chk("rresp", {29'h0, 1'h1, er}, 32'({S_AXI_RVALID_O, S_AXI_RRESP_O}));
      chk("rdata", ed, S_AXI_RDATA_O);
      S_AXI_RREADY_I <= 1'h0;
   endtask : rd

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   // hang guard
   always @(posedge CLK_I) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   // ==========================================================
   // test sequence
   initial begin
      tick(8);
      POR_I <= 1'h0;
      RESET_I <= 1'h0;
      tick(8);
      // power-on state
      chk("analog", 32'h2f, 32'(ANALOG_EN_O));
      chk("oe", 32'h0, 32'(PIN_OE_O));
      rd(ADR_DIR, 32'h3f, OK);
      rd(ADR_DATA, 32'h10, OK);
      // unimplemented bits and read-back
      wr(ADR_DIR, 32'hff, 4'h1, OK);
      rd(ADR_DIR, 32'h3f, OK);
      wr(ADR_CFG, 32'hff, 4'h1, OK);
      wr(ADR_CFG, 32'h00, 4'h0, OK);
      rd(ADR_CFG, 32'h8f, OK);
      chk("fmt", 32'h1, 32'(RESULT_FMT_O));
      // every pin-select setting
      for (int k = 0; k < 16; k++) begin
         wr(ADR_CFG, 32'(k), 4'h1, OK);
         tick(2);
         chk("analog", 32'(AMASK[k]), 32'(ANALOG_EN_O));
         chk("ref", 32'(REFS[k]), 32'(REF_SEL_O));
      end
      // all digital, reads give pins, writes go to latch
      wr(ADR_CFG, 32'h06, 4'h1, OK);
      ext_val <= 6'h3a;
      tick(8);
      rd(ADR_DATA, 32'h3a, OK);
      wr(ADR_DATA, 32'h15, 4'h1, OK);
      rd(ADR_DATA, 32'h3a, OK);
      chk("oe", 32'h0, 32'(PIN_OE_O));
      wr(ADR_DIR, 32'h00, 4'h1, OK);
      chk("oe", 32'h2f, 32'(PIN_OE_O));
      chk("out", 32'h05, 32'(PIN_O));
      tick(8);
      rd(ADR_DATA, 32'h15, OK);
      wr(ADR_DATA, 32'h00, 4'h1, OK);
      chk("oe", 32'h3f, 32'(PIN_OE_O));
      // read-modify-write takes the pin levels into the whole latch
      wr(ADR_DIR, 32'h0f, 4'h1, OK);
      tick(8);
      wr(ADR_DATA, 32'h3f, 4'h0, OK);
      wr(ADR_DIR, 32'h00, 4'h1, OK);
      chk("out", 32'h0a, 32'(PIN_O));
      // shared inputs and peripheral takeover of pin five
      // enable low freezes the drivers; the takeover lands once it returns
      CE_I <= 1'h0;
      SS_PERIPH_EN_I <= 1'h1;
      tick(3);
      chk("oe_frozen", 32'h3f, 32'(PIN_OE_O));
      CE_I <= 1'h1;
      tick(3);
      chk("oe", 32'h1f, 32'(PIN_OE_O));
      wr(ADR_DIR, 32'h3f, 4'h1, OK);
      for (int v = 0; v < 2; v++) begin
         ext_val <= (v == 1) ? 6'h3a : 6'h0a;
         tick(8);
         chk("ss", 32'(v), 32'(SS_O));
         chk("tmr", 32'(v), 32'(TMR_CLK_O));
      end
      SS_PERIPH_EN_I <= 1'h0;
      // unmapped and misaligned places
      rd(32'h0000_0018, 32'h0, SBIO_RESP_SLVERR);
      wr(32'h0000_0016, 32'h3f, 4'h1, SBIO_RESP_SLVERR);
      // warm reset keeps the latch
      RESET_I <= 1'h1;
      tick(2);
      RESET_I <= 1'h0;
      tick(2);
      chk("analog", 32'h2f, 32'(ANALOG_EN_O));
      rd(ADR_DIR, 32'h3f, OK);
      wr(ADR_DIR, 32'h00, 4'h1, OK);
      chk("out", 32'h0a, 32'(PIN_O));
      chk("oe", 32'h3f, 32'(PIN_OE_O));
      // power-on reset clears it
      POR_I <= 1'h1;
      tick(2);
      POR_I <= 1'h0;
      tick(2);
      wr(ADR_DIR, 32'h00, 4'h1, OK);
      chk("out", 32'h00, 32'(PIN_O));
      stop_test();
   end
endmodule : tb
